// *** asf_status_regs.sv ***
`timescale 1ns/1ns
module asf_status_regs
  import asf_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic [6:0] dev_addr_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [7:0] dc_diag_ch34_i,
  input  wire logic [3:0] line_out_det_i,
  input  wire logic [7:0] ch_state_i,
  input  wire logic [3:0] oc_event_i,
  input  wire logic [3:0] dc_event_i,
  input  wire logic       clk_fault_i,
  input  wire logic       stage_over_i,
  input  wire logic       batt_over_i,
  input  wire logic       stage_under_i,
  input  wire logic       batt_under_i,
  input  wire logic       tsd_glob_i,
  input  wire logic [3:0] tsd_ch_i,
  input  wire logic       tw_glob_i,
  input  wire logic [3:0] tw_ch_i,
  input  wire logic       ilimit_i,
  input  wire logic       clip_i,
  input  wire logic       clear_fault_i,
  input  wire logic       mask_ilimit_warn_i,
  output logic            fault_o,
  output logic            warn_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] pins_s;
  logic       scl_q;
  logic       sda_q;

  asf_sync3 #(.W(2), .RST(2'b11)) u_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   ({scl_i, sda_i}),
    .sync_o    (pins_s)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins_s[1];
      sda_q <= pins_s[0];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = pins_s[1] & ~scl_q;
  assign scl_fall  = ~pins_s[1] & scl_q;
  assign bus_start = pins_s[1] & scl_q & sda_q & ~pins_s[0];
  assign bus_stop  = pins_s[1] & scl_q & ~sda_q & pins_s[0];

  // ----------------------------------------
  // Latched flags and channel state
  // ----------------------------------------
  logic [7:0] diag_ch34;
  logic [3:0] line_out;
  logic [7:0] ch_fault;
  logic [4:0] glb_a;
  logic [4:0] glb_b;
  logic [5:0] warn_flags;
  logic [7:0] chan_state;
  logic [7:0] route;

  asf_flag_bank #(.W(8), .RST(RST_ZERO)) u_diag (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .set_i     (dc_diag_ch34_i),
    .clr_i     (clear_fault_i),
    .flag_o    (diag_ch34)
  );

  asf_flag_bank #(.W(4), .RST(RST_ZERO[3:0])) u_line (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .set_i     (line_out_det_i),
    .clr_i     (clear_fault_i),
    .flag_o    (line_out)
  );

  asf_flag_bank #(.W(8), .RST(RST_ZERO)) u_chflt (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .set_i     ({oc_event_i, dc_event_i}),
    .clr_i     (clear_fault_i),
    .flag_o    (ch_fault)
  );

  asf_flag_bank #(.W(5), .RST(RST_ZERO[4:0])) u_glba (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .set_i     ({clk_fault_i, stage_over_i, batt_over_i, stage_under_i, batt_under_i}),
    .clr_i     (clear_fault_i),
    .flag_o    (glb_a)
  );

  asf_flag_bank #(.W(5), .RST(RST_ZERO[4:0])) u_glbb (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .set_i     ({tsd_glob_i, tsd_ch_i}),
    .clr_i     (clear_fault_i),
    .flag_o    (glb_b)
  );

  // Power-on flag set by reset itself, gone only on a clear
  asf_flag_bank #(.W(6), .RST(RST_WARN)) u_warn (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .set_i     ({1'b0, tw_glob_i, tw_ch_i}),
    .clr_i     (clear_fault_i),
    .flag_o    (warn_flags)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      chan_state <= RST_STATE;
    end else begin
      chan_state <= ch_state_i;
    end
  end

  // ----------------------------------------
  // Read decode, pure so reads never disturb flags
  // ----------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0] off);
    case (off)
      OFF_DIAG_CH34:  read_reg = diag_ch34;
      OFF_LINE_OUT:   read_reg = {4'h0, line_out};
      OFF_CH_STATE:   read_reg = chan_state;
      OFF_CH_FAULT:   read_reg = ch_fault;
      OFF_GLB_FAULTA: read_reg = {3'h0, glb_a};
      OFF_GLB_FAULTB: read_reg = {3'h0, glb_b};
      OFF_WARN:       read_reg = {2'h0, warn_flags};
      OFF_ROUTE:      read_reg = route;
      default:        read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // ----------------------------------------
  // Serial slave engine
  // ----------------------------------------
  asf_state_e state;
  logic [3:0] bits;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic       rw;
  logic       ptr_done;
  logic       nack;
  logic       drv;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_cur;

  // Process form so flag changes behind the function are seen
  always_comb begin
    rd_cur = read_reg(ptr);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state    <= ASF_IDLE;
      bits     <= 4'h0;
      sh       <= 8'h00;
      tx       <= 8'h00;
      ptr      <= 8'h00;
      rw       <= 1'b0;
      ptr_done <= 1'b0;
      nack     <= 1'b0;
      drv      <= 1'b0;
      wr_stb   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        state <= ASF_ADDR;
        bits  <= 4'h0;
        drv   <= 1'b0;
      end else if (bus_stop) begin
        state <= ASF_IDLE;
        drv   <= 1'b0;
      end else begin
        case (state)
          ASF_IDLE: begin
            drv <= 1'b0;
          end
          ASF_ADDR: begin
            if (scl_rise) begin
              sh   <= {sh[6:0], pins_s[0]};
              bits <= bits + 4'h1;
            end else if (scl_fall && bits == BITS_PER_BYTE) begin
              if (sh[7:1] == dev_addr_i) begin
                rw       <= sh[0];
                ptr_done <= 1'b0;
                drv      <= 1'b1;
                state    <= ASF_ADDR_ACK;
              end else begin
                state <= ASF_IDLE;
              end
            end
          end
          ASF_ADDR_ACK: begin
            if (scl_fall) begin
              bits <= 4'h0;
              if (rw) begin
                tx    <= rd_cur;
                drv   <= ~rd_cur[7];
                state <= ASF_RD_BYTE;
              end else begin
                drv   <= 1'b0;
                state <= ASF_WR_BYTE;
              end
            end
          end
          ASF_WR_BYTE: begin
            if (scl_rise) begin
              sh   <= {sh[6:0], pins_s[0]};
              bits <= bits + 4'h1;
            end else if (scl_fall && bits == BITS_PER_BYTE) begin
              drv   <= 1'b1;
              state <= ASF_WR_ACK;
              if (!ptr_done) begin
                ptr      <= sh;
                ptr_done <= 1'b1;
              end else begin
                wr_stb  <= 1'b1;
                wr_addr <= ptr;
                wr_data <= sh;
                ptr     <= ptr + 8'h01;
              end
            end
          end
          ASF_WR_ACK: begin
            if (scl_fall) begin
              drv   <= 1'b0;
              bits  <= 4'h0;
              state <= ASF_WR_BYTE;
            end
          end
          ASF_RD_BYTE: begin
            if (scl_rise) begin
              bits <= bits + 4'h1;
            end else if (scl_fall) begin
              if (bits == BITS_PER_BYTE) begin
                drv   <= 1'b0;
                ptr   <= ptr + 8'h01;
                state <= ASF_RD_ACK;
              end else begin
                tx  <= {tx[6:0], 1'b0};
                drv <= ~tx[6];
              end
            end
          end
          ASF_RD_ACK: begin
            if (scl_rise) begin
              nack <= pins_s[0];
            end else if (scl_fall) begin
              bits <= 4'h0;
              if (nack) begin
                state <= ASF_IDLE;
              end else begin
                tx    <= rd_cur;
                drv   <= ~rd_cur[7];
                state <= ASF_RD_BYTE;
              end
            end
          end
          default: begin
            state <= ASF_IDLE;
            drv   <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = drv;

  // ----------------------------------------
  // Pin routing register
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      route <= RST_ROUTE;
    end else if (wr_stb && wr_addr == OFF_ROUTE) begin
      route <= wr_data;
    end
  end

  // ----------------------------------------
  // Fault and warning pins
  // ----------------------------------------
  // Clock fault has no routing bit and stays off the pin
  logic next_fault;
  logic next_warn;
  always_comb begin
    next_fault = (route[RT_OC] & |ch_fault[7:4])
               | (route[RT_TSD] & |glb_b)
               | (route[RT_UV] & (glb_a[1] | glb_a[0]))
               | (route[RT_OV] & (glb_a[3] | glb_a[2]))
               | (route[RT_DC] & |ch_fault[3:0])
               | (route[RT_ILIMIT] & ilimit_i);
    next_warn  = (route[RT_CLIP] & clip_i)
               | (route[RT_TW] & |warn_flags[4:0])
               | (ilimit_i & ~mask_ilimit_warn_i);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      fault_o <= 1'b0;
      warn_o  <= 1'b0;
    end else begin
      fault_o <= next_fault;
      warn_o  <= next_warn;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_diag_ch34_latch: assert property (!clear_fault_i |=>
                                      (diag_ch34 & $past(dc_diag_ch34_i)) == $past(dc_diag_ch34_i))
    else $error("diagnostic result not latched");
  a_line_out_latch: assert property (!clear_fault_i |=>
                                     (line_out & $past(line_out_det_i)) == $past(line_out_det_i))
    else $error("line output result not latched");
  a_state_follow: assert property (##1 chan_state == $past(ch_state_i))
    else $error("channel state readback stale");
  a_state_reset_val: assert property ($rose(nrst_i) |-> chan_state == RST_STATE)
    else $error("channel state reset value wrong");
  a_oc_sets_flag: assert property (oc_event_i[0] |=> ch_fault[4])
    else $error("overcurrent flag lost");
  a_por_flag_reset: assert property ($rose(nrst_i) |-> warn_flags == RST_WARN)
    else $error("warnings reset value wrong");
  a_oc_to_pin: assert property ((ch_fault[7] && route[RT_OC] && !wr_stb) |=> fault_o)
    else $error("routed overcurrent missing on fault pin");
  a_tsd_to_pin: assert property ((glb_b[4] && route[RT_TSD] && !wr_stb) |=> fault_o)
    else $error("routed shutdown missing on fault pin");
  a_uv_to_pin: assert property ((glb_a[0] && route[RT_UV] && !wr_stb) |=> fault_o)
    else $error("routed undervoltage missing on fault pin");
  a_route_off_quiet: assert property (route == 8'h00 && !wr_stb |=> !fault_o)
    else $error("fault pin set with all routes off");
  a_ilimit_warn: assert property ((ilimit_i && !mask_ilimit_warn_i) |=> warn_o)
    else $error("current limit missing on warn pin");
  a_clear_empties: assert property ((clear_fault_i && oc_event_i == 4'h0 && dc_event_i == 4'h0)
                                    |=> ch_fault == 8'h00)
    else $error("clear did not empty channel faults");
  a_flags_sticky: assert property ((ch_fault[0] && !clear_fault_i) |=>
                                   ch_fault[0] [*1] ##0 $stable(ch_fault[0]))
    else $error("channel fault dropped without clear");

  c_route_write: cover property (wr_stb && wr_addr == OFF_ROUTE);
  c_read_byte:   cover property (state == ASF_RD_BYTE && scl_fall);
  c_fault_rise:  cover property ($rose(fault_o));
  c_clear:       cover property (clear_fault_i && |ch_fault);

endmodule : asf_status_regs

// *** asf_pkg.sv ***
package asf_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_DIAG_CH34  = 8'h0D;
  localparam logic [7:0] OFF_LINE_OUT   = 8'h0E;
  localparam logic [7:0] OFF_CH_STATE   = 8'h0F;
  localparam logic [7:0] OFF_CH_FAULT   = 8'h10;
  localparam logic [7:0] OFF_GLB_FAULTA = 8'h11;
  localparam logic [7:0] OFF_GLB_FAULTB = 8'h12;
  localparam logic [7:0] OFF_WARN       = 8'h13;
  localparam logic [7:0] OFF_ROUTE      = 8'h14;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_STATE = 8'h55;
  localparam logic [5:0] RST_WARN  = 6'h20;
  localparam logic [7:0] RST_ROUTE = 8'hFF;

  // ----------------------------------------
  // Pin-routing bit positions
  // ----------------------------------------
  localparam int RT_OC     = 7;
  localparam int RT_TSD    = 6;
  localparam int RT_UV     = 5;
  localparam int RT_OV     = 4;
  localparam int RT_DC     = 3;
  localparam int RT_ILIMIT = 2;
  localparam int RT_CLIP   = 1;
  localparam int RT_TW     = 0;

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [6:0] {
    ASF_IDLE     = 7'b0000001,
    ASF_ADDR     = 7'b0000010,
    ASF_ADDR_ACK = 7'b0000100,
    ASF_WR_BYTE  = 7'b0001000,
    ASF_WR_ACK   = 7'b0010000,
    ASF_RD_BYTE  = 7'b0100000,
    ASF_RD_ACK   = 7'b1000000
  } asf_state_e;

endpackage : asf_pkg

// *** asf_sync3.sv ***
`timescale 1ns/1ns
module asf_sync3
  import asf_pkg::*;
#(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Change accepted only once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      s1     <= RST;
      s2     <= RST;
      s3     <= RST;
      sync_o <= RST;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_o <= s3;
      end
    end
  end
endmodule : asf_sync3

// *** asf_flag_bank.sv ***
`timescale 1ns/1ns
module asf_flag_bank
  import asf_pkg::*;
#(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic         clr_i,
  output logic      [W-1:0] flag_o
);
  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      flag_o <= RST;
    end else begin
      flag_o <= set_i | (clr_i ? '0 : flag_o);
    end
  end
endmodule : asf_flag_bank

// *** asf_host_model.sv ***
`timescale 1ns/1ns
module asf_host_model
  import asf_pkg::*;
#(
  parameter int HALF = 12
) (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  // Phases above the 10-clock minimum, margin for the pin synchronisers
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic half_per();
    repeat (HALF) @(negedge clk_sys_i);
  endtask : half_per

  // Data sampled at the end of the high phase, where it is settled
  task automatic clk_bit(output logic v);
    half_per();
    scl_o = 1'b1;
    half_per();
    v     = sda_i;
    scl_o = 1'b0;
  endtask : clk_bit

  // Also a repeated start: data released before the clock rises
  task automatic start_c();
    sda_oe_o = 1'b0;
    half_per();
    scl_o = 1'b1;
    half_per();
    sda_oe_o = 1'b1;
    half_per();
    scl_o = 1'b0;
  endtask : start_c

  task automatic stop_c();
    sda_oe_o = 1'b1;
    half_per();
    scl_o = 1'b1;
    half_per();
    sda_oe_o = 1'b0;
    half_per();
  endtask : stop_c

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      sda_oe_o = ~b[i];
      clk_bit(v);
    end
    sda_oe_o = 1'b0;
    clk_bit(v);
    ack = ~v;
  endtask : put_byte

  // Last byte answered with a release, so the device stops driving
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic v;
    sda_oe_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v);
      b[i] = v;
    end
    sda_oe_o = ~last;
    clk_bit(v);
    sda_oe_o = 1'b0;
  endtask : get_byte
endmodule : asf_host_model

// *** test_amp_status_fault_report_regs.sv ***
`timescale 1ns/1ns
module test_amp_status_fault_report_regs;
  import asf_pkg::*;
  typedef struct packed {logic [3:0] e; logic [7:0] rt; logic mk; logic f; logic w;} asf_case_s;
  localparam logic [6:0] DEV = 7'h4C;
  logic       clk, nrst, scl, h_oe, d_sda, d_oe, clk_flt, st_ov, bt_ov, st_uv, bt_uv;
  logic       tsd_g, tw_g, ilim, clip, clr, mk_il, fault, warn;
  logic [7:0] dc_dg, ch_st;
  logic [3:0] lo_det, oc, dc, tsd_c, tw_c;
  logic [7:0] ex [10];
  int         fail_count, checked, cyc;
  wire        sda = ~(h_oe | d_oe);
  asf_case_s  tab [18] = '{
    '{4'h0, 8'h00, 1'h0, 1'h0, 1'h0},
    '{4'h0, 8'h7F, 1'h0, 1'h0, 1'h0}, '{4'h0, 8'h80, 1'h0, 1'h1, 1'h0},
    '{4'h1, 8'hBF, 1'h0, 1'h0, 1'h0}, '{4'h1, 8'h40, 1'h0, 1'h1, 1'h0},
    '{4'h2, 8'hDF, 1'h0, 1'h0, 1'h0}, '{4'h2, 8'h20, 1'h0, 1'h1, 1'h0},
    '{4'h3, 8'hEF, 1'h0, 1'h0, 1'h0}, '{4'h3, 8'h10, 1'h0, 1'h1, 1'h0},
    '{4'h4, 8'hF7, 1'h0, 1'h0, 1'h0}, '{4'h4, 8'h08, 1'h0, 1'h1, 1'h0},
    '{4'h5, 8'hFB, 1'h1, 1'h0, 1'h0}, '{4'h5, 8'h04, 1'h0, 1'h1, 1'h1},
    '{4'h5, 8'h04, 1'h1, 1'h1, 1'h0}, '{4'h6, 8'hFD, 1'h0, 1'h0, 1'h0},
    '{4'h6, 8'h02, 1'h0, 1'h0, 1'h1}, '{4'h7, 8'hFE, 1'h0, 1'h0, 1'h0},
    '{4'h7, 8'h01, 1'h0, 1'h0, 1'h1}};

  asf_status_regs asf_status_regs_inst (
    .clk_sys_i(clk), .nrst_i(nrst), .dev_addr_i(DEV), .scl_i(scl), .sda_i(sda),
    .sda_o(d_sda), .sda_oe_o(d_oe), .dc_diag_ch34_i(dc_dg), .line_out_det_i(lo_det),
    .ch_state_i(ch_st), .oc_event_i(oc), .dc_event_i(dc), .clk_fault_i(clk_flt),
    .stage_over_i(st_ov), .batt_over_i(bt_ov), .stage_under_i(st_uv), .batt_under_i(bt_uv),
    .tsd_glob_i(tsd_g), .tsd_ch_i(tsd_c), .tw_glob_i(tw_g), .tw_ch_i(tw_c), .ilimit_i(ilim),
    .clip_i(clip), .clear_fault_i(clr), .mask_ilimit_warn_i(mk_il), .fault_o(fault), .warn_o(warn));

  asf_host_model asf_host_model_inst (
    .clk_sys_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Serial accesses
  // ----------------------------------------
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic a;
    asf_host_model_inst.start_c();
    asf_host_model_inst.put_byte({DEV, 1'h0}, a);
    check({7'h00, a}, 8'h01);
    asf_host_model_inst.put_byte(p, a);
    asf_host_model_inst.put_byte(d, a);
    asf_host_model_inst.stop_c();
  endtask : wr

  // Burst read with auto-increment, compared against ex
  task automatic rd_chk(input logic [7:0] p, input int n);
    logic       a;
    logic [7:0] b;
    asf_host_model_inst.start_c();
    asf_host_model_inst.put_byte({DEV, 1'h0}, a);
    asf_host_model_inst.put_byte(p, a);
    asf_host_model_inst.start_c();
    asf_host_model_inst.put_byte({DEV, 1'h1}, a);
    for (int i = 0; i < n; i++) begin
      asf_host_model_inst.get_byte(i == n - 1, b);
      check(b, ex[i]);
    end
    asf_host_model_inst.stop_c();
  endtask : rd_chk

  task automatic set_ev(input logic [3:0] e, input logic v);
    case (e)
      4'h0: oc[3] = v;
      4'h1: tsd_c[0] = v;
      4'h2: st_uv = v;
      4'h3: bt_ov = v;
      4'h4: dc[1] = v;
      4'h5: ilim = v;
      4'h6: clip = v;
      default: tw_g = v;
    endcase
  endtask : set_ev

  // ----------------------------------------
  // Clock, timeout and tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    {nrst, clk_flt, st_ov, bt_ov, st_uv, bt_uv, tsd_g, tw_g, ilim, clip, clr, mk_il} = '0;
    {dc_dg, lo_det, oc, dc, tsd_c, tw_c} = '0;
    ch_st = 8'h55;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check({6'h00, fault, warn}, 8'h00);
    ex = '{8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h20, 8'hFF, 8'h00};
    rd_chk(8'h0C, 10);
    check({6'h00, d_sda, d_oe}, 8'h00);
    $display("test reset_map done");
    @(negedge clk);
    {dc_dg, lo_det, oc, dc, tsd_c, tw_c} = {8'hA5, 4'h9, 4'hD, 4'h3, 4'h5, 4'hA};
    {clk_flt, st_ov, bt_uv, tsd_g} = 4'hF;
    ch_st = 8'h1B;
    @(negedge clk);
    {dc_dg, lo_det, oc, dc, tsd_c, tw_c} = '0;
    {clk_flt, st_ov, bt_uv, tsd_g} = 4'h0;
    repeat (3) @(negedge clk);
    check({6'h00, fault, warn}, 8'h03);
    ex = '{8'h00, 8'hA5, 8'h09, 8'h1B, 8'hD3, 8'h19, 8'h15, 8'h2A, 8'hFF, 8'h00};
    for (int k = 0; k < 2; k++) rd_chk(8'h0C, 10);
    $display("test flag_map done");
    foreach (tab[k]) begin
      wr(OFF_ROUTE, tab[k].rt);
      mk_il = tab[k].mk;
      clr   = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      set_ev(tab[k].e, 1'b1);
      @(negedge clk);
      if (tab[k].e != 4'h5 && tab[k].e != 4'h6) set_ev(tab[k].e, 1'b0);
      repeat (3) @(negedge clk);
      check({6'h00, fault, warn}, {6'h00, tab[k].f, tab[k].w});
      set_ev(tab[k].e, 1'b0);
    end
    $display("test pin_routing done");
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    wr(OFF_CH_FAULT, 8'hFF);
    ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rd_chk(OFF_CH_FAULT, 5);
    asf_host_model_inst.start_c();
    asf_host_model_inst.put_byte({DEV ^ 7'h01, 1'h1}, clip);
    check({7'h00, clip}, 8'h00);
    clip = 1'b0;
    asf_host_model_inst.stop_c();
    $display("test clear_refuse done");
    final_report();
  end
endmodule : test_amp_status_fault_report_regs
